// ==== design/intprio_pkg.sv ====
// package: register map, field layout and reset values of the priority registers
package intprio_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned PRIO_W = 3;
  localparam int unsigned NUM_SRC = 6;

  // ---------------------------------------------------------------------------
  // register offsets (word index)
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADC_SERIAL_TX_PRIORITY_OFS  = 4'h0;
  localparam logic [ADDR_W-1:0] CHANGE_CMP_I2C_PRIORITY_OFS = 4'h1;

  // ---------------------------------------------------------------------------
  // field positions (low bit of each 3-bit field)
  // ---------------------------------------------------------------------------
  localparam int unsigned CONVERTER_DONE_PRIO_POS = 4;
  localparam int unsigned SERIAL0_TX_PRIO_POS     = 0;
  localparam int unsigned PIN_CHANGE_PRIO_POS     = 12;
  localparam int unsigned COMPARATOR_PRIO_POS     = 8;
  localparam int unsigned I2C0_MASTER_PRIO_POS    = 4;
  localparam int unsigned I2C0_SLAVE_PRIO_POS     = 0;

  // implemented bits of each register
  localparam logic [DATA_W-1:0] ADC_SERIAL_TX_PRIORITY_MASK  = 16'h0077;
  localparam logic [DATA_W-1:0] CHANGE_CMP_I2C_PRIORITY_MASK = 16'h7777;

  // ---------------------------------------------------------------------------
  // reset values and special codes
  // ---------------------------------------------------------------------------
  localparam logic [PRIO_W-1:0] PRIO_RESET    = 3'h4;
  localparam logic [PRIO_W-1:0] PRIO_DISABLED = 3'h0;

  // source index order of the request and level vectors
  typedef enum logic [2:0] {
    INTPRIO_SRC_CONVERTER_DONE,
    INTPRIO_SRC_SERIAL0_TX,
    INTPRIO_SRC_PIN_CHANGE,
    INTPRIO_SRC_COMPARATOR,
    INTPRIO_SRC_I2C0_MASTER,
    INTPRIO_SRC_I2C0_SLAVE
  } intprio_src_t;

  typedef struct packed {
    logic [PRIO_W-1:0] converterDone;
    logic [PRIO_W-1:0] serial0Tx;
    logic [PRIO_W-1:0] pinChange;
    logic [PRIO_W-1:0] comparator;
    logic [PRIO_W-1:0] i2c0Master;
    logic [PRIO_W-1:0] i2c0Slave;
  } intprio_fields_t;

  localparam intprio_fields_t FIELDS_RESET = '{
    converterDone: PRIO_RESET,
    serial0Tx:     PRIO_RESET,
    pinChange:     PRIO_RESET,
    comparator:    PRIO_RESET,
    i2c0Master:    PRIO_RESET,
    i2c0Slave:     PRIO_RESET
  };

endpackage

// ==== design/intprio_regs.sv ====
// module: interrupt priority control registers with per-source level outputs
// -----------------------------------------------------------------------------
// Overview of operation
// RULE1: unimplemented bits read zero, writes ignored
// RULE2: converter-done priority at bits 6:4, reset 100
// RULE3: serial0 transmit priority at bits 2:0, reset 100
// RULE4: code 111 is level 7, highest
// RULE5: code 001 is level 1; codes map binary
// RULE6: code 000 never raises an interrupt
// RULE7: second register holds four fields, reset 100
// -----------------------------------------------------------------------------
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/10ps

module intprio_regs (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              clkEn,
  input  wire logic [intprio_pkg::ADDR_W-1:0]    regAddr,
  input  wire logic [intprio_pkg::DATA_W-1:0]    regWrData,
  input  wire logic                              regWrEn,
  input  wire logic                              regRdEn,
  output logic      [intprio_pkg::DATA_W-1:0]    regRdData,
  input  wire logic [intprio_pkg::NUM_SRC-1:0]   srcReq,
  output logic      [intprio_pkg::NUM_SRC*3-1:0] srcLevel,
  output logic      [intprio_pkg::NUM_SRC-1:0]   srcActive,
  output intprio_pkg::intprio_fields_t           prioFields
);

  // ---------------------------------------------------------------------------
  // reset synchroniser
  // ---------------------------------------------------------------------------
  logic rstMeta_reg;
  logic rstSync_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  localparam int unsigned PW = intprio_pkg::PRIO_W;
  localparam int unsigned DW = intprio_pkg::DATA_W;
  localparam int unsigned AW = intprio_pkg::ADDR_W;
  localparam int unsigned NS = intprio_pkg::NUM_SRC;

  // priority code maps straight to its level; 000 means the source is off
  function automatic logic [PW-1:0] levelOf(
    input logic [PW-1:0] code,
    input logic          req
  );
    logic [PW-1:0] lvl;
    lvl = intprio_pkg::PRIO_DISABLED;
    if (req && (code != intprio_pkg::PRIO_DISABLED)) begin  // see RULE6
      lvl = code;  // see RULE4 see RULE5
    end
    return lvl;
  endfunction

  // a source is active only while its effective level is nonzero
  function automatic logic activeOf(
    input logic [PW-1:0] code,
    input logic          req
  );
    return levelOf(code, req) != intprio_pkg::PRIO_DISABLED;  // see RULE6
  endfunction

  // pulls one 3-bit field out of a bus word
  function automatic logic [PW-1:0] fieldOf(
    input logic [DW-1:0] word,
    input int unsigned   pos
  );
    return word[pos +: PW];
  endfunction

  // word-index compare shared by the write and read decoders
  function automatic logic hitsAddr(
    input logic [AW-1:0] addr,
    input logic [AW-1:0] ofs
  );
    return addr == ofs;
  endfunction

  // first register image; bits outside its fields stay zero
  function automatic logic [DW-1:0] packFirst(
    input intprio_pkg::intprio_fields_t f
  );
    logic [DW-1:0] w;
    w = '0;
    w[intprio_pkg::CONVERTER_DONE_PRIO_POS +: PW] = f.converterDone;  // see RULE2
    w[intprio_pkg::SERIAL0_TX_PRIO_POS +: PW]     = f.serial0Tx;      // see RULE3
    return w & intprio_pkg::ADC_SERIAL_TX_PRIORITY_MASK;              // see RULE1
  endfunction

  // second register image; bits 15, 11, 7 and 3 stay zero
  function automatic logic [DW-1:0] packSecond(
    input intprio_pkg::intprio_fields_t f
  );
    logic [DW-1:0] w;
    w = '0;
    w[intprio_pkg::PIN_CHANGE_PRIO_POS +: PW]  = f.pinChange;   // see RULE7
    w[intprio_pkg::COMPARATOR_PRIO_POS +: PW]  = f.comparator;
    w[intprio_pkg::I2C0_MASTER_PRIO_POS +: PW] = f.i2c0Master;
    w[intprio_pkg::I2C0_SLAVE_PRIO_POS +: PW]  = f.i2c0Slave;
    return w & intprio_pkg::CHANGE_CMP_I2C_PRIORITY_MASK;       // see RULE1
  endfunction

  // ---------------------------------------------------------------------------
  // strobe decode
  // ---------------------------------------------------------------------------
  logic wrFirst;
  logic wrSecond;
  logic rdFirst;
  logic rdSecond;

  // unmapped indices decode to nothing: writes drop, reads return zero
  always_comb begin
    wrFirst  = regWrEn && hitsAddr(regAddr, intprio_pkg::ADC_SERIAL_TX_PRIORITY_OFS);
    wrSecond = regWrEn && hitsAddr(regAddr, intprio_pkg::CHANGE_CMP_I2C_PRIORITY_OFS);
    rdFirst  = regRdEn && hitsAddr(regAddr, intprio_pkg::ADC_SERIAL_TX_PRIORITY_OFS);
    rdSecond = regRdEn && hitsAddr(regAddr, intprio_pkg::CHANGE_CMP_I2C_PRIORITY_OFS);
  end

  // ---------------------------------------------------------------------------
  // priority fields
  // ---------------------------------------------------------------------------
  intprio_pkg::intprio_fields_t fields_reg;
  intprio_pkg::intprio_fields_t fields_next;

  // only the implemented bits of the write word reach a field
  always_comb begin
    fields_next = fields_reg;
    if (wrFirst) begin
      fields_next.converterDone = fieldOf(regWrData, intprio_pkg::CONVERTER_DONE_PRIO_POS);
      fields_next.serial0Tx     = fieldOf(regWrData, intprio_pkg::SERIAL0_TX_PRIO_POS);
    end else if (wrSecond) begin
      fields_next.pinChange  = fieldOf(regWrData, intprio_pkg::PIN_CHANGE_PRIO_POS);
      fields_next.comparator = fieldOf(regWrData, intprio_pkg::COMPARATOR_PRIO_POS);
      fields_next.i2c0Master = fieldOf(regWrData, intprio_pkg::I2C0_MASTER_PRIO_POS);
      fields_next.i2c0Slave  = fieldOf(regWrData, intprio_pkg::I2C0_SLAVE_PRIO_POS);
    end
  end

  always_ff @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      fields_reg <= intprio_pkg::FIELDS_RESET;  // see RULE2 see RULE3 see RULE7
    end else if (clkEn) begin
      fields_reg <= fields_next;
    end
  end

  // ---------------------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------------------
  logic [DW-1:0] rdData_reg;
  logic [DW-1:0] rdData_next;

  // read data stand until the next edge with clkEn high, then fall back to zero
  always_comb begin
    rdData_next = '0;
    if (rdFirst) begin
      rdData_next = packFirst(fields_reg);   // see RULE1
    end else if (rdSecond) begin
      rdData_next = packSecond(fields_reg);  // see RULE1
    end
  end

  always_ff @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      rdData_reg <= '0;
    end else if (clkEn) begin
      rdData_reg <= rdData_next;
    end
  end

  // ---------------------------------------------------------------------------
  // per-source effective level
  // ---------------------------------------------------------------------------
  logic [NS*PW-1:0] level_reg;
  logic [NS*PW-1:0] level_next;
  logic [NS-1:0]    active_reg;
  logic [NS-1:0]    active_next;
  logic [NS*PW-1:0] codes;

  // codes ordered by source index, converter done in the low slot
  always_comb begin
    codes = {fields_reg.i2c0Slave,
             fields_reg.i2c0Master,
             fields_reg.comparator,
             fields_reg.pinChange,
             fields_reg.serial0Tx,
             fields_reg.converterDone};
    level_next  = '0;
    active_next = '0;
    for (int i = 0; i < NS; i++) begin
      level_next[i*PW +: PW] = levelOf(codes[i*PW +: PW], srcReq[i]);   // see RULE4 see RULE5
      active_next[i]         = activeOf(codes[i*PW +: PW], srcReq[i]);  // see RULE6
    end
  end

  always_ff @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      level_reg  <= '0;
      active_reg <= '0;
    end else if (clkEn) begin
      level_reg  <= level_next;
      active_reg <= active_next;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign regRdData  = rdData_reg;
  assign srcLevel   = level_reg;
  assign srcActive  = active_reg;
  assign prioFields = fields_reg;

endmodule

// ==== bench/intprio_regs_props.sv ====
// checker: concurrent properties of the priority registers
`timescale 1ns/10ps
module intprio_regs_props (
  input wire logic                         clk,
  input wire logic                         rst_n,
  input wire logic                         clkEn,
  input wire logic [3:0]                   regAddr,
  input wire logic [15:0]                  regWrData,
  input wire logic                         regWrEn,
  input wire logic                         regRdEn,
  input wire logic [15:0]                  regRdData,
  input wire logic [5:0]                   srcReq,
  input wire logic [17:0]                  srcLevel,
  input wire logic [5:0]                   srcActive,
  input wire intprio_pkg::intprio_fields_t prioFields
);
  logic [17:0] expLevel;
  logic [5:0]  expActive;
  logic [11:0] wrF;
  always_comb begin
    wrF = {regWrData[14:12], regWrData[10:8], regWrData[6:4], regWrData[2:0]};
    for (int i = 0; i < 6; i++) begin
      expLevel[3*i+:3] = srcReq[i] ? prioFields[15-3*i+:3] : 3'h0;
      expActive[i] = srcLevel[3*i+:3] != 3'h0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence wrFirst; clkEn && regWrEn && regAddr == 4'h0; endsequence
  sequence rdFirst; clkEn && regRdEn && regAddr == 4'h0; endsequence
  chk_rd_idle: assert property (clkEn && !regRdEn |=> regRdData == 16'h0)
    else $error("read data not zero");
  chk_unimpl_first: assert property (rdFirst |=> (regRdData & 16'hFF88) == 16'h0)
    else $error("unimplemented bit set");
  chk_unimpl_second: assert property (clkEn && regRdEn && regAddr == 4'h1
    |=> (regRdData & 16'h8888) == 16'h0) else $error("unimplemented bit set");
  chk_rd_unmapped: assert property (clkEn && regRdEn && regAddr > 4'h1
    |=> regRdData == 16'h0) else $error("unmapped read not zero");
  chk_level_match: assert property (clkEn && !regWrEn
    |=> srcLevel == $past(expLevel)) else $error("source level wrong");
  chk_active_match: assert property (srcActive == expActive)
    else $error("active flag wrong");
  chk_write_back: assert property (wrFirst ##1 rdFirst
    |=> regRdData == ($past(regWrData, 2) & 16'h0077)) else $error("readback wrong");
  chk_second_fields: assert property (clkEn && regWrEn && regAddr == 4'h1
    |=> prioFields[11:0] == $past(wrF)) else $error("second register fields wrong");
endmodule
bind intprio_regs intprio_regs_props chk (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData(regRdData), .srcReq(srcReq), .srcLevel(srcLevel), .srcActive(srcActive),
  .prioFields(prioFields));

// ==== bench/testbench.sv ====
// testbench: corner and random checks of the priority registers
`timescale 1ns/10ps
module testbench;
  logic        clk = 0, rst_n = 0, clkEn = 1, regWrEn = 0, regRdEn = 0;
  logic [3:0]  regAddr = 4'h0;
  logic [3:0]  cor [3] = '{4'hF, 4'h9, 4'h8};
  logic [15:0] regWrData = 16'h0, regRdData, d;
  logic [15:0] shadow [2] = '{16'h0044, 16'h4444};
  logic [5:0]  srcReq = 6'h0, srcActive, act;
  logic [17:0] srcLevel, f, lv;
  intprio_pkg::intprio_fields_t prioFields;
  int          fails = 0, checkCount = 0, cycles = 0;
  intprio_regs uut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .srcReq(srcReq), .srcLevel(srcLevel), .srcActive(srcActive), .prioFields(prioFields));
  initial forever #2 clk = ~clk;
  task automatic cmp(input logic [17:0] got, input logic [17:0] want);
    checkCount++;
    if (got !== want) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic stop_test;
    if (fails == 0 && checkCount > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // optional write, then a read of the same address with no gap
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] v, input logic e);
    if (w) begin
      regWrEn <= 1'h1;
      regAddr <= a;
      regWrData <= v;
      clkEn <= e;
      @(posedge clk);
      if (e && a < 4'h2) shadow[a[0]] = v & (a[0] ? 16'h7777 : 16'h0077);
    end
    regWrEn <= 1'h0;
    clkEn <= 1'h1;
    regRdEn <= 1'h1;
    regAddr <= a;
    @(posedge clk);
    regRdEn <= 1'h0;
    #1;
    cmp(regRdData, a < 4'h2 ? shadow[a[0]] : 16'h0);
    @(posedge clk);
  endtask
  task automatic lvl(input logic [5:0] r);
    srcReq <= r;
    repeat (2) @(posedge clk);
    #1;
    f = {shadow[0][6:4], shadow[0][2:0], shadow[1][14:12], shadow[1][10:8], shadow[1][6:4],
      shadow[1][2:0]};
    for (int i = 0; i < 6; i++) begin
      lv[3*i+:3] = r[i] ? f[15-3*i+:3] : 3'h0;
      act[i] = lv[3*i+:3] != 3'h0;
    end
    cmp(prioFields, f);
    cmp(srcLevel, lv);
    cmp(srcActive, act);
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(32'h4351));
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    acc(1'h0, 4'h0, 16'h0, 1'h1);
    acc(1'h0, 4'h1, 16'h0, 1'h1);
    acc(1'h0, 4'hB, 16'h0, 1'h1);
    lvl(6'h3F);
    for (int i = 0; i < 60; i++) begin
      d = (i < 6) ? {4{cor[i/2]}} : 16'($urandom);
      acc(1'h1, (i < 6) ? 4'(i % 2) : 4'($urandom_range(2)), d, i % 9 != 8);
      lvl(6'($urandom));
    end
    stop_test();
  end
endmodule
